// ---- rtl/ocd_codec_pkg.sv ----
/*
  Shared constants and types for the OFDM channel descriptor builder:
  register map, field positions, parameter codes, reset values, timing.
  Assumes a single 25 MHz system clock.
*/
package chd_codec_pkg;

  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1000000;                      // Repeat interval unit, 1 ms
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CHAN     = 8'h04;
  localparam logic [7:0] ADDR_PHY      = 8'h08;
  localparam logic [7:0] ADDR_FREQ     = 8'h0c;
  localparam logic [7:0] ADDR_SUBC_HDR = 8'h10;
  localparam logic [7:0] ADDR_SUBC_IDX = 8'h14;
  localparam logic [7:0] ADDR_INTERVAL = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_INT_STAT = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h24;

  // Control bits
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_PRIM_BIT = 1;
  localparam int CTRL_RCS_BIT  = 2;

  // Interrupt bits
  localparam int INT_W       = 3;
  localparam int INT_SENT    = 0;
  localparam int INT_LOCKED  = 1;
  localparam int INT_ILLEGAL = 2;

  // Parameter types and lengths
  localparam logic [7:0] TLV_FFT   = 8'h00;
  localparam logic [7:0] TLV_CP    = 8'h01;
  localparam logic [7:0] TLV_RO    = 8'h02;
  localparam logic [7:0] TLV_FREQ  = 8'h03;
  localparam logic [7:0] TLV_DEPTH = 8'h04;
  localparam logic [7:0] TLV_SUBC  = 8'h05;
  localparam logic [7:0] TLV_PRIM  = 8'h06;
  localparam logic [7:0] LEN_ONE   = 8'h01;
  localparam logic [7:0] LEN_FREQ  = 8'h04;
  localparam logic [7:0] LEN_SUBC  = 8'h05;

  // Parameter codes and limits
  localparam logic [7:0]  FFT_4K       = 8'h00;
  localparam logic [7:0]  FFT_8K       = 8'h01;
  localparam logic [7:0]  CP_MAX       = 8'h04;
  localparam logic [7:0]  RO_MAX       = 8'h04;
  localparam logic [7:0]  DEPTH_MAX_4K = 8'h20;
  localparam logic [7:0]  DEPTH_MAX_8K = 8'h10;
  localparam logic [31:0] SPACING_4K   = 32'h0000c350;          // 50 kHz
  localparam logic [31:0] SPACING_8K   = 32'h000061a8;          // 25 kHz
  localparam logic [1:0]  MODE_RSVD    = 2'h3;
  localparam logic [4:0]  KIND_PILOT   = 5'h01;
  localparam logic [4:0]  KIND_EXCL    = 5'h10;
  localparam logic [4:0]  KIND_LINK    = 5'h14;

  // Frame: channel, change count, 29 bytes of parameters minus channel byte
  localparam int FRAME_BYTES = 30;

  // Reset values
  localparam logic [31:0] PHY_RST      = 32'h01000000;          // Depth 1, others code 0
  localparam logic [7:0]  SUBC_HDR_RST = 8'h30;                 // Default, excluded range
  localparam logic [15:0] INTERVAL_RST = 16'h0064;

  // Physical parameter word
  typedef struct packed {
    logic [7:0] depth;
    logic [7:0] ro;
    logic [7:0] cp;
    logic [7:0] fft;
  } phy_t;

  // One byte of the outgoing stream
  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } beat_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } tx_state_t;

endpackage

// ---- rtl/ocd_tick_div.sv ----
/*
  Divider giving a one-cycle enable pulse every CYCLES clocks.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module chd_tick_div #(
  parameter int CYCLES = 25000
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  initial begin
    if (CYCLES < 2) $error("chd_tick_div: CYCLES must be at least 2");
  end

  logic [31:0] cnt_ff;
  logic        tick_ff;
  wire         wrap = (cnt_ff == 32'(CYCLES - 1));

  // Free-running count, pulse on wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 32'h00000000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 32'h00000000 : cnt_ff + 32'h00000001;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;
endmodule

// ---- rtl/ocd_builder.sv ----
/*
  Headend-side builder of the OFDM channel descriptor message. Software sets
  the channel and parameters over a plain register port; the block validates
  them, snapshots a frame at each repeat interval and streams it byte by byte
  toward the physical link channel of the described channel.
  Assumes a MAC stream sink on CLK_SYS with valid/ready handshake.
*/
`timescale 1ns/100ps
module chd_builder
  import chd_codec_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [31:0] RD_DATA,
  output beat_t            TX_BEAT,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic      [7:0]  TX_CHAN,
  output logic             IRQ
);
  initial begin
    if (TICK_LEN < 2) $error("chd_builder: TICK_LEN must be at least 2");
  end

  logic [2:0]             ctrl_ff;
  logic [7:0]             chan_ff;
  phy_t                   phy_ff;
  logic [31:0]            freq_ff;
  logic [7:0]             subc_hdr_ff;
  logic [31:0]            subc_idx_ff;
  logic [15:0]            interval_ff;
  logic [7:0]             ccc_ff;
  logic                   sent_once_ff;
  logic [(FRAME_BYTES-1)*8-1:0] last_body_ff;
  logic [FRAME_BYTES*8-1:0]     shift_ff;
  logic [4:0]             idx_ff;
  logic [15:0]            tick_cnt_ff;
  tx_state_t              state_ff;
  beat_t                  beat_ff;
  logic                   valid_ff;
  logic [7:0]             txchan_ff;
  logic [INT_W-1:0]       int_stat_ff;
  logic [INT_W-1:0]       int_mask_ff;
  logic                   irq_ff;
  logic [31:0]            rdata_ff;
  logic                   tick;

  // Repeat interval time base
  chd_tick_div #(.CYCLES(TICK_LEN)) u_tick (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (tick)
  );

  // Address decode
  wire wr_ctrl   = WR_EN && (ADDR == ADDR_CTRL);
  wire wr_chan   = WR_EN && (ADDR == ADDR_CHAN);
  wire wr_phy    = WR_EN && (ADDR == ADDR_PHY);
  wire wr_freq   = WR_EN && (ADDR == ADDR_FREQ);
  wire wr_shdr   = WR_EN && (ADDR == ADDR_SUBC_HDR);
  wire wr_sidx   = WR_EN && (ADDR == ADDR_SUBC_IDX);
  wire wr_intv   = WR_EN && (ADDR == ADDR_INTERVAL);
  wire wr_istat  = WR_EN && (ADDR == ADDR_INT_STAT);
  wire wr_imask  = WR_EN && (ADDR == ADDR_INT_MASK);
  wire wr_param  = wr_chan || wr_phy || wr_freq || wr_shdr || wr_sidx;
  wire locked    = ctrl_ff[CTRL_RCS_BIT];

  // Validation of written parameter values
  phy_t      wphy;
  assign wphy = phy_t'(WR_DATA);
  wire [7:0] depth_max = (wphy.fft == FFT_8K) ? DEPTH_MAX_8K : DEPTH_MAX_4K;
  wire       freq_ok_4k = ((freq_ff % SPACING_4K) == 32'h00000000);
  wire       freq_ok_8k = ((freq_ff % SPACING_8K) == 32'h00000000);
  wire       phy_ok = (wphy.fft <= FFT_8K) && (wphy.cp <= CP_MAX) && (wphy.ro <= RO_MAX)
                   && (wphy.depth != 8'h00) && (wphy.depth <= depth_max)
                   && ((wphy.fft == FFT_8K) ? freq_ok_8k : freq_ok_4k);
  wire       nfreq_ok = (phy_ff.fft == FFT_8K) ? ((WR_DATA % SPACING_8K) == 32'h00000000)
                                               : ((WR_DATA % SPACING_4K) == 32'h00000000);
  wire [4:0] wkind = WR_DATA[4:0];
  wire       shdr_ok = (WR_DATA[7:6] != MODE_RSVD)
                    && ((wkind == KIND_PILOT) || (wkind == KIND_EXCL) || (wkind == KIND_LINK));
  wire       bad_val = (wr_phy && !phy_ok) || (wr_freq && !nfreq_ok) || (wr_shdr && !shdr_ok);
  wire       refuse_lock = wr_param && locked;
  wire       accept = !locked && !bad_val;

  // Configuration registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_ff     <= 3'h0;
      chan_ff     <= 8'h00;
      phy_ff      <= PHY_RST;
      freq_ff     <= 32'h00000000;
      subc_hdr_ff <= SUBC_HDR_RST;
      subc_idx_ff <= 32'h00000000;
      interval_ff <= INTERVAL_RST;
      int_mask_ff <= '0;
    end else begin
      if (wr_ctrl) ctrl_ff <= WR_DATA[2:0];
      if (wr_chan && accept) chan_ff <= WR_DATA[7:0];
      if (wr_phy && accept) phy_ff <= wphy;
      if (wr_freq && accept) freq_ff <= WR_DATA;
      if (wr_shdr && accept) subc_hdr_ff <= WR_DATA[7:0];
      if (wr_sidx && accept) subc_idx_ff <= WR_DATA;
      if (wr_intv) interval_ff <= WR_DATA[15:0];
      if (wr_imask) int_mask_ff <= WR_DATA[INT_W-1:0];
    end
  end

  // Frame body without the change-count byte: channel, then type, length, value per parameter
  wire [7:0] prim_val = {7'h00, ctrl_ff[CTRL_PRIM_BIT]};
  wire [(FRAME_BYTES-1)*8-1:0] body = {
    chan_ff,
    TLV_FFT,   LEN_ONE,  phy_ff.fft,
    TLV_CP,    LEN_ONE,  phy_ff.cp,
    TLV_RO,    LEN_ONE,  phy_ff.ro,
    TLV_FREQ,  LEN_FREQ, freq_ff,
    TLV_DEPTH, LEN_ONE,  phy_ff.depth,
    TLV_SUBC,  LEN_SUBC, subc_hdr_ff, subc_idx_ff[15:0], subc_idx_ff[31:16],
    TLV_PRIM,  LEN_ONE,  prim_val
  };

  // Repeat scheduling
  wire        intv_hit = (tick_cnt_ff + 16'h0001 >= interval_ff);
  wire        start = ctrl_ff[CTRL_EN_BIT] && (state_ff == ST_IDLE) && tick && intv_hit;
  wire        changed = sent_once_ff && (body != last_body_ff);
  wire [7:0]  nxt_ccc = changed ? ccc_ff + 8'h01 : ccc_ff;
  wire        hs = valid_ff && TX_READY;
  wire        last_beat = (idx_ff == 5'(FRAME_BYTES - 1));
  wire [FRAME_BYTES*8-1:0] snap = {body[(FRAME_BYTES-1)*8-1 -: 8], nxt_ccc,
                                   body[(FRAME_BYTES-2)*8-1:0]};

  // Interval counter, counts ticks since the last frame start
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) tick_cnt_ff <= 16'h0000;
    else if (start) tick_cnt_ff <= 16'h0000;
    else if (tick && !intv_hit) tick_cnt_ff <= tick_cnt_ff + 16'h0001;
  end

  // Change count and snapshot of the last frame content
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ccc_ff       <= 8'h00;
      sent_once_ff <= 1'b0;
      last_body_ff <= '0;
    end else if (start) begin
      ccc_ff       <= nxt_ccc;
      sent_once_ff <= 1'b1;
      last_body_ff <= body;
    end
  end

  // Byte sender; destination is the described channel's own link channel
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_ff  <= ST_IDLE;
      shift_ff  <= '0;
      idx_ff    <= 5'h00;
      beat_ff   <= '0;
      valid_ff  <= 1'b0;
      txchan_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff  <= ST_SEND;
            shift_ff  <= snap << 8;
            idx_ff    <= 5'h00;
            beat_ff   <= '{data: snap[FRAME_BYTES*8-1 -: 8], first: 1'b1, last: 1'b0};
            valid_ff  <= 1'b1;
            txchan_ff <= chan_ff;
          end
        end
        ST_SEND: begin
          if (hs) begin
            if (beat_ff.last) begin
              state_ff <= ST_IDLE;
              valid_ff <= 1'b0;
              beat_ff  <= '0;
            end else begin
              shift_ff <= shift_ff << 8;
              idx_ff   <= idx_ff + 5'h01;
              beat_ff  <= '{data: shift_ff[FRAME_BYTES*8-1 -: 8], first: 1'b0,
                            last: (idx_ff == 5'(FRAME_BYTES - 2))};
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Interrupt events; a set in the same cycle as a clear wins
  wire [INT_W-1:0] ev = {bad_val && !locked, refuse_lock, hs && beat_ff.last};
  wire [INT_W-1:0] clr = wr_istat ? WR_DATA[INT_W-1:0] : '0;
  wire [INT_W-1:0] nxt_int_stat = (int_stat_ff & ~clr) | ev;

  // Read mux
  wire [31:0] rmux =
      (ADDR == ADDR_CTRL)     ? {29'h0, ctrl_ff} :
      (ADDR == ADDR_CHAN)     ? {24'h0, chan_ff} :
      (ADDR == ADDR_PHY)      ? phy_ff :
      (ADDR == ADDR_FREQ)     ? freq_ff :
      (ADDR == ADDR_SUBC_HDR) ? {24'h0, subc_hdr_ff} :
      (ADDR == ADDR_SUBC_IDX) ? subc_idx_ff :
      (ADDR == ADDR_INTERVAL) ? {16'h0, interval_ff} :
      (ADDR == ADDR_STATUS)   ? {23'h0, valid_ff, ccc_ff} :
      (ADDR == ADDR_INT_STAT) ? {29'h0, int_stat_ff} :
      (ADDR == ADDR_INT_MASK) ? {29'h0, int_mask_ff} : 32'h00000000;

  // Status, interrupt and read data flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      int_stat_ff <= '0;
      irq_ff      <= 1'b0;
      rdata_ff    <= 32'h00000000;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff      <= |(nxt_int_stat & int_mask_ff);
      rdata_ff    <= RD_EN ? rmux : 32'h00000000;
    end
  end

  assign RD_DATA  = rdata_ff;
  assign TX_BEAT  = beat_ff;
  assign TX_VALID = valid_ff;
  assign TX_CHAN  = txchan_ff;
  assign IRQ      = irq_ff;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_chan_first;
    TX_VALID && TX_BEAT.first |-> TX_BEAT.data == TX_CHAN;
  endproperty
  a_chan_first: assert property (p_chan_first) else $error("first byte is not channel id");

  property p_ccc_step;
    start && changed |=> ccc_ff == $past(ccc_ff) + 8'h01;
  endproperty
  a_ccc_step: assert property (p_ccc_step) else $error("change count did not step");

  property p_ccc_hold;
    start && !changed |=> $stable(ccc_ff);
  endproperty
  a_ccc_hold: assert property (p_ccc_hold) else $error("change count moved without change");

  property p_dest_stable;
    TX_VALID && !TX_BEAT.first |-> $stable(TX_CHAN);
  endproperty
  a_dest_stable: assert property (p_dest_stable) else $error("destination moved in frame");

  property p_lock;
    wr_phy && locked |=> $stable(phy_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("parameter changed while in use");

  property p_repeat;
    $rose(TX_VALID) |-> $past(ctrl_ff[CTRL_EN_BIT] && tick && intv_hit);
  endproperty
  a_repeat: assert property (p_repeat) else $error("frame started off interval");

  property p_codes;
    phy_ff.fft <= FFT_8K && phy_ff.cp <= CP_MAX && phy_ff.ro <= RO_MAX;
  endproperty
  a_codes: assert property (p_codes) else $error("reserved physical code stored");

  property p_depth;
    phy_ff.depth != 8'h00 && phy_ff.depth <= ((phy_ff.fft == FFT_8K) ? DEPTH_MAX_8K : DEPTH_MAX_4K);
  endproperty
  a_depth: assert property (p_depth) else $error("interleave depth out of range");

  property p_mode;
    subc_hdr_ff[7:6] != MODE_RSVD;
  endproperty
  a_mode: assert property (p_mode) else $error("reserved assignment mode stored");

  property p_prim_last;
    TX_VALID && TX_BEAT.last |-> TX_BEAT.data <= 8'h01 && last_beat;
  endproperty
  a_prim_last: assert property (p_prim_last) else $error("bad final byte or frame length");

  property p_irq;
    ev[INT_SENT] && int_mask_ff[INT_SENT] |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_frame_done: cover property (hs && TX_BEAT.last);
  c_ccc_bump: cover property (start && changed);
  c_locked: cover property (refuse_lock);
  c_stall: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
endmodule

// ---- test/ocd_rx_model.sv ----
/*
  Modem-side sink for the channel descriptor stream: accepts beats, can stall,
  rebuilds each frame and flags reserved codes or wrong type/length bytes.
  Assumes the builder's beat_t stream on the same clock and reset.
*/
`timescale 1ns/100ps
module chd_rx_model
  import chd_codec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire beat_t      beat,
  input  wire logic       valid,
  input  wire logic [7:0] chan,
  input  wire logic       slow,
  output logic            ready,
  output logic [7:0]      frm [0:29],
  output int              n_frames,
  output int              gap,
  output logic            err,
  output logic [7:0]      chan_id,
  output logic            chan_bad
);
  logic [7:0] buf_q [0:29];
  int         pos;
  int         now;
  int         t0;

  // Reserved codes, bad spacing or misplaced type/length bytes
  function automatic logic bad_frame();
    logic [31:0] f;
    f = {buf_q[13], buf_q[14], buf_q[15], buf_q[16]};
    bad_frame = {buf_q[2], buf_q[3], buf_q[5], buf_q[6], buf_q[8], buf_q[9]} !== {TLV_FFT, LEN_ONE, TLV_CP, LEN_ONE,
                TLV_RO, LEN_ONE} || {buf_q[11], buf_q[12], buf_q[17], buf_q[18]} !== {TLV_FREQ, LEN_FREQ, TLV_DEPTH,
                LEN_ONE} || {buf_q[20], buf_q[21], buf_q[27], buf_q[28]} !== {TLV_SUBC, LEN_SUBC, TLV_PRIM, LEN_ONE};
    bad_frame |= buf_q[4] > FFT_8K || buf_q[7] > CP_MAX || buf_q[10] > RO_MAX;
    bad_frame |= f % (buf_q[4][0] ? SPACING_8K : SPACING_4K) != 0;
    bad_frame |= buf_q[19] == 8'h00 || buf_q[19] > (buf_q[4][0] ? DEPTH_MAX_8K : DEPTH_MAX_4K);
    bad_frame |= buf_q[22][7:6] == MODE_RSVD || !(buf_q[22][4:0] inside {KIND_PILOT, KIND_EXCL, KIND_LINK});
    bad_frame |= buf_q[29] > 8'h01;
  endfunction

  // Sink: optional stall on every other cycle, frame capture and parse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
      n_frames <= 0;
      gap <= 0;
      err <= 1'b0;
      chan_id <= 8'h00;
      chan_bad <= 1'b0;
      pos = 0;
      now = 0;
      t0 = 0;
    end else begin
      now = now + 1;
      ready <= slow ? ~ready : 1'b1;
      if (valid && ready) begin
        if (beat.first) begin
          pos = 0;
          gap <= now - t0;
          t0 = now;
          chan_bad <= chan_bad | (chan !== beat.data);
        end
        buf_q[pos] = beat.data;
        pos = pos + 1;
        if (beat.last) begin
          frm <= buf_q;
          n_frames <= n_frames + 1;
          chan_id <= buf_q[0];
          err <= err | bad_frame() | (pos != FRAME_BYTES);
        end
      end
    end
  end
endmodule

// ---- test/tb.sv ----
/*
  Testbench for the descriptor builder: register tasks, frame checks against
  expectations built here, refusals, lock, interrupts and repeat spacing.
  Assumes the modem-side sink model and a short tick divider.
*/
`timescale 1ns/100ps
module tb
  import chd_codec_pkg::*;
;
  localparam int          TL = 4;
  localparam logic [7:0]  RA [0:10] = '{ADDR_CTRL, ADDR_CHAN, ADDR_PHY, ADDR_FREQ, ADDR_SUBC_HDR, ADDR_SUBC_IDX,
                                        ADDR_INTERVAL, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK, 8'h40};
  localparam logic [31:0] RV [0:10] = '{0, 0, PHY_RST, 0, {24'h0, SUBC_HDR_RST}, 0, {16'h0, INTERVAL_RST}, 0, 0, 0, 0};
  localparam logic [7:0]  CA [0:4]  = '{ADDR_CHAN, ADDR_PHY, ADDR_FREQ, ADDR_SUBC_HDR, ADDR_SUBC_IDX};
  localparam logic [7:0]  BA [0:9]  = '{ADDR_PHY, ADDR_PHY, ADDR_PHY, ADDR_PHY, ADDR_PHY, ADDR_PHY, ADDR_FREQ,
                                        ADDR_SUBC_HDR, ADDR_SUBC_HDR, ADDR_SUBC_HDR};
  localparam logic [31:0] BD [0:9]  = '{32'h08020302, 32'h08020500, 32'h08050300, 32'h00020300, 32'h21020300,
                                        32'h11020301, 32'h1dcdc6a8, 32'h000000d0, 32'h00000002, 32'h00000000};
  logic        clk_sys;
  logic        rst;
  logic        wr_en;
  logic        rd_en;
  logic        tx_valid;
  logic        tx_ready;
  logic        irq;
  logic        slow;
  logic        err;
  logic        chan_bad;
  logic [7:0]  addr;
  logic [7:0]  tx_chan;
  logic [7:0]  chan_id;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  beat_t       tx_beat;
  logic [7:0]  frm [0:29];
  int          n_frames;
  int          gap;
  int          n_mismatch;
  int          compares;
  logic [7:0]  e_chan;
  logic [7:0]  e_ccc;
  logic [7:0]  e_hdr;
  logic [7:0]  e_prim;
  phy_t        e_phy;
  logic [31:0] e_freq;
  logic [31:0] e_idx;
  logic [7:0]  ex [0:29];
  logic [7:0]  prev [0:29];
  logic        have_prev;

  chd_builder #(.TICK_LEN(TL)) chd_builder_i (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .TX_BEAT(tx_beat), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_CHAN(tx_chan), .IRQ(irq));
  chd_rx_model chd_rx_model_i (.clk(clk_sys), .rst(rst), .beat(tx_beat), .valid(tx_valid), .chan(tx_chan),
    .slow(slow), .ready(tx_ready), .frm(frm), .n_frames(n_frames), .gap(gap), .err(err), .chan_id(chan_id),
    .chan_bad(chan_bad));

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Register write and read, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic chkr(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(what, rd_data, exp);
  endtask

  function automatic logic [31:0] cur(input logic [7:0] a);
    case (a)
      ADDR_CHAN:     cur = {24'h0, e_chan};
      ADDR_PHY:      cur = e_phy;
      ADDR_FREQ:     cur = e_freq;
      ADDR_SUBC_HDR: cur = {24'h0, e_hdr};
      default:       cur = e_idx;
    endcase
  endfunction

  // Stop sending and let any frame in flight drain, then reload settings
  task automatic restart(input logic [31:0] ctrl);
    wr(ADDR_CTRL, ctrl & 32'h6);
    cyc(100);
    for (int i = 0; i < 5; i++) wr(CA[i], cur(CA[i]));
    wr(ADDR_INT_STAT, 32'h7);
    wr(ADDR_CTRL, ctrl);
  endtask

  // Wait for the next whole frame and compare it byte by byte
  task automatic check_frame(input string tname);
    int n0;
    logic same;
    n0 = n_frames;
    for (int i = 0; i < 3000 && n_frames == n0; i++) @(posedge clk_sys);
    #1;
    chk("frame seen", 32'(n_frames != n0), 32'h1);
    ex = '{e_chan, e_ccc, TLV_FFT, LEN_ONE, e_phy.fft, TLV_CP, LEN_ONE, e_phy.cp, TLV_RO, LEN_ONE, e_phy.ro,
           TLV_FREQ, LEN_FREQ, e_freq[31:24], e_freq[23:16], e_freq[15:8], e_freq[7:0], TLV_DEPTH, LEN_ONE,
           e_phy.depth, TLV_SUBC, LEN_SUBC, e_hdr, e_idx[15:8], e_idx[7:0], e_idx[31:24], e_idx[23:16],
           TLV_PRIM, LEN_ONE, e_prim};
    same = 1'b1;
    for (int i = 0; i < 30; i++) if (i != 1 && ex[i] !== prev[i]) same = 1'b0;
    if (have_prev && !same) e_ccc = e_ccc + 8'h01;
    ex[1] = e_ccc;
    prev = ex;
    have_prev = 1'b1;
    for (int i = 0; i < 30; i++) chk("frame byte", frm[i], ex[i]);
    chk("learned channel", chan_id, e_chan);
    chk("link channel", chan_bad, 1'b0);
    chk("destination", tx_chan, e_chan);
    chk("parse error", err, 1'b0);
    $display("test %s done, %0d mismatches so far", tname, n_mismatch);
  endtask

  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog, about sixty times the expected run
  initial begin
    #(40 * 80000);
    n_mismatch++;
    give_verdict();
  end

  // Test sequence
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    slow = 1'b0;
    n_mismatch = 0;
    compares = 0;
    have_prev = 1'b0;
    e_ccc = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wr(ADDR_STATUS, 32'h1ff);
    wr(8'h40, 32'hffffffff);
    for (int i = 0; i < 11; i++) chkr("reset value", RA[i], RV[i]);
    cyc(1);
    chk("read data idle", rd_data, 32'h0);
    $display("test reset values done");
    // First frame, interrupt raised and cleared
    e_chan = 8'h05;
    e_phy = 32'h08020300;
    e_freq = 32'h1dcd6500;
    e_hdr = 8'h10;
    e_idx = 32'h00930000;
    e_prim = 8'h01;
    wr(ADDR_INTERVAL, 32'h1);
    wr(ADDR_INT_MASK, 32'h1);
    restart(32'h3);
    check_frame("first frame");
    cyc(3);
    chk("irq raised", irq, 1'b1);
    wr(ADDR_CTRL, 32'h2);
    cyc(100);
    chkr("change count", ADDR_STATUS, {24'h0, e_ccc});
    wr(ADDR_INT_STAT, 32'h1);
    cyc(2);
    chk("irq cleared", irq, 1'b0);
    // Masked event: status set but no interrupt; unchanged content keeps the count
    wr(ADDR_INT_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    check_frame("same content");
    cyc(3);
    chk("irq masked", irq, 1'b0);
    chkr("sent status", ADDR_INT_STAT, 32'h1);
    e_phy.ro = 8'h04;
    restart(32'h3);
    check_frame("changed content");
    // Refused values leave registers untouched and flag an error
    wr(ADDR_CTRL, 32'h2);
    cyc(100);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_INT_STAT, 32'h7);
      wr(BA[i], BD[i]);
      chkr("refused value", BA[i], cur(BA[i]));
      chkr("illegal flag", ADDR_INT_STAT, 32'h4);
    end
    // Every non-reserved mode, both value flags and each listed kind are accepted
    for (int m = 0; m < 3; m++)
      for (int d = 0; d < 2; d++)
        for (int k = 0; k < 3; k++) begin
          e_hdr = {m[1:0], d[0], k == 0 ? KIND_PILOT : k == 1 ? KIND_EXCL : KIND_LINK};
          wr(ADDR_SUBC_HDR, {24'h0, e_hdr});
          chkr("assignment header", ADDR_SUBC_HDR, {24'h0, e_hdr});
        end
    $display("test refusals done");
    // 8K transform with 25 kHz frequency step, sink stalling
    e_chan = 8'hff;
    e_phy = 32'h10020301;
    e_freq = 32'h1dcdc6a8;
    e_prim = 8'h00;
    slow = 1'b1;
    restart(32'h1);
    check_frame("8K stalled");
    slow = 1'b0;
    wr(ADDR_PHY, 32'h10020300);
    chkr("spacing recheck", ADDR_PHY, e_phy);
    // Repeat spacing follows the interval
    wr(ADDR_INTERVAL, 32'd20);
    restart(32'h1);
    check_frame("interval a");
    check_frame("interval b");
    chk("repeat gap", gap, 20 * TL);
    // Lock refuses parameter changes and raises its own flag
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_INT_STAT, 32'h7);
    wr(ADDR_INT_MASK, 32'h2);
    wr(ADDR_CHAN, 32'h9);
    wr(ADDR_PHY, 32'h00000000);
    chkr("locked channel", ADDR_CHAN, {24'h0, e_chan});
    chkr("locked flags", ADDR_INT_STAT, 32'h2);
    cyc(2);
    chk("lock irq", irq, 1'b1);
    check_frame("locked");
    give_verdict();
  end
endmodule
